/* enhanced_pwm_output_startup_tb_top.sv */
// Self-checking testbench of the PWM output stage.
`timescale 1ns/1ps
module enhanced_pwm_output_startup_tb_top;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, flt_n = 1;
  logic awrdy, wrdy, bv, arrdy, rv, irq;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat;
  logic [1:0] brsp, rrsp;
  logic [5:0] gate;
  pwm_out_pkg::pins_s pins;
  int num_errors = 0, total_checks = 0, seed = 90811, cyc = 0, v, n;
  int q[$];
  int ofs[9] = '{0, 1, 2, 3, 4, 5, 6, 7, 10};
  int msk[9] = '{3, 255, 127, 31, 255, 255, 255, 15, 3};
  int ca[10] = '{28, 0, 8, 12, 16, 20, 24, 4, 36, 40};
  int cd[10] = '{0, 0, 0, 1, 0, 3, 0, 0, 3, 1};

  always #2 clk = ~clk;

  pwm_out_stage DUT (.CORE_CLK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(brsp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rrsp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre),
    .FAULT_IN_N(flt_n), .CMP_IN(1'b0), .PINS(pins), .IRQ(irq));
  pwr_bridge bridge (.pins(pins), .gate(gate));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Each channel is released at its own handshake; the response is awaited with a bound.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    int k;
    @(posedge clk);
    k = 0;
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    bre <= 1;
    do begin
      @(posedge clk);
      if (awrdy) awv <= 0;
      if (wrdy) wv <= 0;
      k++;
    end while (!bv && k < 200);
    bre <= 0;
    chk(brsp, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int k;
    @(posedge clk);
    k = 0;
    ara <= a;
    arv <= 1;
    rre <= 1;
    do begin
      @(posedge clk);
      if (arrdy) arv <= 0;
      k++;
    end while (!rv && k < 200);
    rre <= 0;
    chk(rdat, e);
    chk(rrsp, r);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 11; i++) if (i != 9) rd(8'(i * 4), i == 5 ? 32'hff : 0, 0);
    rd(8'h2c, 0, 2'b10);
    wr(8'h2c, 8'h55, 2'b10);
    foreach (ofs[i]) begin
      v = $random(seed) & (ofs[i] == 2 ? 127 : 255);
      wr(8'(ofs[i] * 4), 8'(v), 0);
      q.push_back(v & msk[i]);
    end
    foreach (ofs[i]) rd(8'(ofs[i] * 4), q.pop_front(), 0);
    foreach (ca[i]) wr(8'(ca[i]), 8'(cd[i]), 0);
    wr(8'h04, 8'h0c, 0);
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(n >= 12 && n <= 40, 1);
    wr(8'h04, 0, 0);
    wr(8'h28, 0, 0);
    @(posedge clk);
    chk(irq, 0);
    rd(8'h20, 1, 0);
    wr(8'h24, 1, 0);
    rd(8'h20, 0, 0);
    chk(gate, 0);
    // Polarity is only changed with the drivers off, and a full cycle runs first.
    for (int p = 0; p < 4; p += 3) begin
      wr(8'h1c, 0, 0);
      wr(8'h04, 8'(12 + p), 0);
      repeat (40) @(posedge clk);
      wr(8'h1c, 8'h0f, 0);
      repeat (4) @(posedge clk);
      chk(gate[0], p[1]);
    end
    wr(8'h00, 8'h01, 0);
    repeat (2) @(posedge clk);
    chk({pins.oe[4], pins.oe[0]}, 2'b10);
    wr(8'h00, 0, 0);
    wr(8'h08, 8'h20, 0);
    flt_n <= 0;
    repeat (8) @(posedge clk);
    chk(gate[0], 0);
    wr(8'h08, 8'h20, 0);
    rd(8'h08, 8'ha0, 0);
    flt_n <= 1;
    repeat (4) @(posedge clk);
    wr(8'h08, 8'h20, 0);
    rd(8'h08, 8'h20, 0);
    // Half bridge with a one-cycle dead band: each 8-clock half loses one instruction cycle.
    wr(8'h1c, 0, 0);
    wr(8'h18, 8'h02, 0);
    wr(8'h10, 8'h01, 0);
    wr(8'h04, 8'h8c, 0);
    repeat (40) @(posedge clk);
    wr(8'h1c, 8'h0f, 0);
    repeat (8) @(posedge clk);
    v = 0;
    n = 0;
    for (int j = 0; j < 32; j++) begin
      @(posedge clk);
      v += gate[0];
      n += gate[1];
      if (gate[0] && gate[1]) total_checks += 0;
      chk(gate[0] & gate[1], 0);
    end
    chk(v, 8);
    chk(n, 8);
    // Synchronised steering waits for the next period start.
    wr(8'h1c, 0, 0);
    wr(8'h18, 8'hff, 0);
    wr(8'h0c, 8'h01, 0);
    wr(8'h04, 8'h0c, 0);
    wr(8'h1c, 8'h0f, 0);
    wr(8'h28, 8'h01, 0);
    wr(8'h24, 8'h01, 0);
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    wr(8'h0c, 8'h12, 0);
    repeat (2) @(posedge clk);
    chk(gate[1:0], 2'b01);
    repeat (16) @(posedge clk);
    chk(gate[1:0], 2'b10);
    stop_test();
  end
endmodule

/* pwm_deadband.sv */
// Delays the inactive-to-active edge of one output by a count of instruction cycles.
`timescale 1ns/1ps
module pwm_deadband (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [6:0] count,
  input wire logic active_in,
  output logic active_out
);
  pwm_out_pkg::db_s s_r;
  pwm_out_pkg::db_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!active_in) begin
      s_nxt.out = 1'b0;
      s_nxt.cnt = 7'h00;
    end else if (!s_r.out) begin
      if (s_r.cnt >= count) begin
        s_nxt.out = 1'b1;
      end else if (tick) begin
        s_nxt.cnt = s_r.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign active_out = s_r.out;
endmodule

/* pwm_out_chk.sv */
// Bus and pin checks for the PWM output stage.
`timescale 1ns/1ps
module pwm_out_chk (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire pwm_out_pkg::pins_s PINS
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  sequence wr_both;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence b_wait;
    S_AXI_BVALID && !S_AXI_BREADY;
  endsequence
  a_write_answer: assert property (wr_both |-> ##[1:2] S_AXI_BVALID) else $error("no write response");
  a_bresp_held: assert property (b_wait |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bresp dropped");
  a_write_once: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID) else $error("bvalid stuck");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("no read data");
  a_rdata_held: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> $stable(S_AXI_RDATA)) else $error("rdata moved");
  a_read_once: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID) else $error("rvalid stuck");
  a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("arready during read");
  a_rdata_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0) else $error("upper bits set");
  a_pins_hiz: assert property ($rose(RESET_N) |-> (PINS.oe == 6'h00) [*2]) else $error("pin driven");
endmodule

bind pwm_out_stage pwm_out_chk chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .PINS(PINS));

/* pwm_out_pkg.sv */
// Types shared by the PWM output stage modules.
package pwm_out_pkg;
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
  } pins_s;

  typedef struct packed {
    logic [6:0] cnt;
    logic out;
  } db_s;

  typedef struct packed {
    logic [7:0] alt;
    logic [7:0] mode;
    logic [7:0] flt;
    logic [7:0] steer;
    logic [7:0] db;
    logic [7:0] per;
    logic [7:0] dutyh;
    logic [7:0] drv;
    logic [3:0] steer_act;
    logic [9:0] duty_act;
    logic [7:0] tmr;
    logic [1:0] q;
    logic [1:0] ists;
    logic [1:0] ien;
    logic sd_act;
    logic [1:0] sync1;
    logic [1:0] sync2;
    pins_s pins;
    logic irq;
    logic aw_h;
    logic w_h;
    logic [7:0] awa;
    logic [7:0] wd;
    logic wstb;
    logic awr;
    logic wr;
    logic bv;
    logic [1:0] br;
    logic arr;
    logic rv;
    logic [7:0] rd;
    logic [1:0] rr;
  } core_s;
endpackage

/* pwm_out_regs.svh */
// Register offsets, field positions, reset values and timing counts of the PWM output stage.
`ifndef PWM_OUT_REGS_SVH
`define PWM_OUT_REGS_SVH

`define OFF_ALT_PIN 8'h00
`define OFF_MODE 8'h04
`define OFF_FAULT 8'h08
`define OFF_STEER 8'h0c
`define OFF_DEADBAND 8'h10
`define OFF_PERIOD 8'h14
`define OFF_DUTY_HIGH 8'h18
`define OFF_DRIVE_EN 8'h1c
`define OFF_INT_STATUS 8'h20
`define OFF_INT_CLEAR 8'h24
`define OFF_INT_ENABLE 8'h28

`define RST_BYTE 8'h00
`define RST_PERIOD 8'hff

`define ALT_B_LOC_BIT 1
`define ALT_PRI_LOC_BIT 0
`define ALT_MASK 8'h03
`define STEER_MASK 8'h1f
`define STEER_SYNC_BIT 4
`define FAULT_STATUS_BIT 7
`define FAULT_SRC_CMP_BIT 4
`define FAULT_SRC_PIN_BIT 5
`define DB_RESTART_BIT 7
`define DRIVE_MASK 8'h0f
`define INT_PERIOD_BIT 0
`define INT_SHUTDOWN_BIT 1

`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`define CLK_PERIOD_NS 4
`define TOSC_NS 4
`define TCY_IN_TOSC 4
`define TCY_CYCLES ((`TOSC_NS * `TCY_IN_TOSC) / `CLK_PERIOD_NS)

`endif

/* pwm_out_stage.sv */
// PWM output stage: registers, period timer, steering, dead band, shutdown and pin drive.
`timescale 1ns/1ps
`include "pwm_out_regs.svh"

// How it works
// - Mode low bits set per-pair output polarity.
// - Period flag sets when second period begins.
// - All pins high-impedance after reset.
// - Alternate register relocates output B and primary.
// - Unimplemented register bits read as zero, except fault bit 6, which reads back as written.
// - Shutdown is level held; status write blocked.
// - Synchronised steering changes at next period start.
// - Half-bridge dead band delays activating edges.
module pwm_out_stage (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic FAULT_IN_N,
  input wire logic CMP_IN,
  output pwm_out_pkg::pins_s PINS,
  output logic IRQ
);
  pwm_out_pkg::core_s s_r;
  pwm_out_pkg::core_s s_nxt;

  logic tick;
  logic pwm_on;
  logic pstart;
  logic pwm_lvl;
  logic half;
  logic [1:0] db_in;
  logic [1:0] db_out;
  logic [6:0] db_count;

  assign tick = (s_r.q == 2'(`TCY_CYCLES - 1));
  assign pwm_on = (s_r.mode[3:2] == 2'b11);
  assign pstart = pwm_on && tick && (s_r.tmr == s_r.per);
  assign pwm_lvl = ({s_r.tmr, s_r.q} < s_r.duty_act);
  assign half = (s_r.mode[7:6] == 2'b10);
  assign db_count = half ? s_r.db[6:0] : 7'h00;
  assign db_in = {~pwm_lvl & pwm_on, pwm_lvl & pwm_on};

  // The two half-bridge outputs each get their own edge delay.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_db
      pwm_deadband u_db (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .tick(tick),
        .count(db_count),
        .active_in(db_in[gi]),
        .active_out(db_out[gi])
      );
    end
  endgenerate

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `OFF_ALT_PIN) || (a == `OFF_MODE) || (a == `OFF_FAULT) ||
             (a == `OFF_STEER) || (a == `OFF_DEADBAND) || (a == `OFF_PERIOD) ||
             (a == `OFF_DUTY_HIGH) || (a == `OFF_DRIVE_EN) || (a == `OFF_INT_STATUS) ||
             (a == `OFF_INT_CLEAR) || (a == `OFF_INT_ENABLE);
  endfunction

  logic wen;
  logic do_wr;
  logic lvl;
  logic st_wr;
  logic [1:0] ev;
  logic [3:0] lg;
  logic [3:0] mask;
  logic [3:0] pol;
  logic [3:0] phys;
  logic [3:0] tri_st;
  logic [3:0] oe4;
  logic [7:0] rdv;

  always_comb begin
    s_nxt = s_r;
    ev = 2'b00;
    rdv = 8'h00;

    // Second flip-flop is the only reader of the first.
    s_nxt.sync1 = {FAULT_IN_N, CMP_IN};
    s_nxt.sync2 = s_r.sync1;

    // Write channel: address and data are held separately, in either order.
    if (s_r.bv && S_AXI_BREADY) begin
      s_nxt.bv = 1'b0;
    end
    if (s_r.awr && S_AXI_AWVALID) begin
      s_nxt.aw_h = 1'b1;
      s_nxt.awa = S_AXI_AWADDR;
    end
    if (s_r.wr && S_AXI_WVALID) begin
      s_nxt.w_h = 1'b1;
      s_nxt.wd = S_AXI_WDATA[7:0];
      s_nxt.wstb = S_AXI_WSTRB[0];
    end
    do_wr = s_r.aw_h && s_r.w_h && !s_r.bv;
    wen = do_wr && s_r.wstb && mapped(s_r.awa);
    if (do_wr) begin
      s_nxt.aw_h = 1'b0;
      s_nxt.w_h = 1'b0;
      s_nxt.bv = 1'b1;
      s_nxt.br = mapped(s_r.awa) ? `AXI_OKAY : `AXI_SLVERR;
    end
    s_nxt.awr = !s_nxt.aw_h;
    s_nxt.wr = !s_nxt.w_h;

    if (wen) begin
      unique case (s_r.awa)
        `OFF_ALT_PIN: s_nxt.alt = s_r.wd & `ALT_MASK;
        `OFF_MODE: s_nxt.mode = s_r.wd;
        `OFF_FAULT: s_nxt.flt[6:0] = s_r.wd[6:0];
        `OFF_STEER: s_nxt.steer = s_r.wd & `STEER_MASK;
        `OFF_DEADBAND: s_nxt.db = s_r.wd;
        `OFF_PERIOD: s_nxt.per = s_r.wd;
        `OFF_DUTY_HIGH: s_nxt.dutyh = s_r.wd;
        `OFF_DRIVE_EN: s_nxt.drv = s_r.wd & `DRIVE_MASK;
        `OFF_INT_ENABLE: s_nxt.ien = s_r.wd[1:0];
        default: ;
      endcase
    end
    // Without sync the new steering lands at once and may cut a pulse short.
    if (wen && (s_r.awa == `OFF_STEER) && !s_r.wd[`STEER_SYNC_BIT]) begin
      s_nxt.steer_act = s_r.wd[3:0];
    end

    // Period timer: instruction cycles divided from the core clock.
    if (!pwm_on) begin
      s_nxt.q = 2'b00;
      s_nxt.tmr = 8'h00;
      s_nxt.duty_act = {s_r.dutyh, s_r.mode[5:4]};
      s_nxt.steer_act = s_nxt.steer[3:0];
    end else begin
      s_nxt.q = s_r.q + 2'b01;
      if (tick) begin
        s_nxt.tmr = s_r.tmr + 8'h01;
      end
      if (pstart) begin
        s_nxt.tmr = 8'h00;
        s_nxt.duty_act = {s_r.dutyh, s_r.mode[5:4]};
        ev[`INT_PERIOD_BIT] = 1'b1;
        if (s_r.steer[`STEER_SYNC_BIT]) begin
          s_nxt.steer_act = s_r.steer[3:0];
        end
      end
    end

    // Shutdown: the level keeps the status set; writes cannot clear it meanwhile.
    lvl = (s_r.flt[`FAULT_SRC_CMP_BIT] & s_r.sync2[0]) |
          (s_r.flt[`FAULT_SRC_PIN_BIT] & ~s_r.sync2[1]);
    st_wr = wen && (s_r.awa == `OFF_FAULT);
    if (lvl) begin
      s_nxt.flt[`FAULT_STATUS_BIT] = 1'b1;
    end else if (st_wr) begin
      s_nxt.flt[`FAULT_STATUS_BIT] = s_r.wd[`FAULT_STATUS_BIT];
    end else if (s_r.db[`DB_RESTART_BIT]) begin
      s_nxt.flt[`FAULT_STATUS_BIT] = 1'b0;
    end
    ev[`INT_SHUTDOWN_BIT] = s_nxt.flt[`FAULT_STATUS_BIT] & ~s_r.flt[`FAULT_STATUS_BIT];
    // Outputs resume only at a period boundary, so a restart is always a whole waveform.
    if (s_nxt.flt[`FAULT_STATUS_BIT]) begin
      s_nxt.sd_act = 1'b1;
    end else if (pstart || !pwm_on) begin
      s_nxt.sd_act = 1'b0;
    end

    // Sticky status: a new event wins over a clear in the same cycle.
    if (wen && (s_r.awa == `OFF_INT_CLEAR)) begin
      s_nxt.ists = s_r.ists & ~s_r.wd[1:0];
    end
    s_nxt.ists = s_nxt.ists | ev;
    s_nxt.irq = |(s_nxt.ists & s_nxt.ien);

    // Output configuration, in A, B, C, D bit order.
    unique case (s_r.mode[7:6])
      2'b00: begin
        lg = {4{pwm_lvl}} & s_r.steer_act;
        mask = s_r.steer_act;
      end
      2'b01: begin
        lg = {pwm_lvl, 1'b0, 1'b0, 1'b1};
        mask = 4'hf;
      end
      2'b10: begin
        lg = {1'b0, 1'b0, db_out[1], db_out[0]};
        mask = 4'h3;
      end
      default: begin
        lg = {1'b0, 1'b1, pwm_lvl, 1'b0};
        mask = 4'hf;
      end
    endcase
    pol = {s_r.mode[0], s_r.mode[1], s_r.mode[0], s_r.mode[1]};
    phys = lg ^ pol;
    tri_st = 4'h0;
    if (s_r.sd_act) begin
      tri_st = {s_r.flt[1], s_r.flt[3], s_r.flt[1], s_r.flt[3]};
      phys = {s_r.flt[0], s_r.flt[2], s_r.flt[0], s_r.flt[2]};
    end
    // Pins drive only once firmware enables their drivers; reset leaves all off.
    oe4 = s_r.drv[3:0] & mask & ~tri_st & {4{pwm_on}};

    // Pins 0..3 are A..D at home; 4 and 5 are the alternate spots for A and B.
    s_nxt.pins.out = {phys[1], phys[0], phys[3], phys[2], phys[1], phys[0]};
    s_nxt.pins.oe[3:2] = oe4[3:2];
    s_nxt.pins.oe[0] = oe4[0] & ~s_r.alt[`ALT_PRI_LOC_BIT];
    s_nxt.pins.oe[4] = oe4[0] & s_r.alt[`ALT_PRI_LOC_BIT];
    s_nxt.pins.oe[1] = oe4[1] & ~s_r.alt[`ALT_B_LOC_BIT];
    s_nxt.pins.oe[5] = oe4[1] & s_r.alt[`ALT_B_LOC_BIT];

    // Read channel.
    if (s_r.rv && S_AXI_RREADY) begin
      s_nxt.rv = 1'b0;
    end
    if (s_r.arr && S_AXI_ARVALID) begin
      unique case (S_AXI_ARADDR)
        `OFF_ALT_PIN: rdv = s_r.alt;
        `OFF_MODE: rdv = s_r.mode;
        `OFF_FAULT: rdv = s_r.flt;
        `OFF_STEER: rdv = s_r.steer;
        `OFF_DEADBAND: rdv = s_r.db;
        `OFF_PERIOD: rdv = s_r.per;
        `OFF_DUTY_HIGH: rdv = s_r.dutyh;
        `OFF_DRIVE_EN: rdv = s_r.drv;
        `OFF_INT_STATUS: rdv = {6'h00, s_r.ists};
        `OFF_INT_ENABLE: rdv = {6'h00, s_r.ien};
        default: rdv = 8'h00;
      endcase
      s_nxt.rv = 1'b1;
      s_nxt.rd = rdv;
      s_nxt.rr = mapped(S_AXI_ARADDR) ? `AXI_OKAY : `AXI_SLVERR;
    end
    s_nxt.arr = !s_nxt.rv;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_r <= '0;
      s_r.per <= `RST_PERIOD;
      s_r.sync1 <= 2'b10;
      s_r.sync2 <= 2'b10;
      s_r.awr <= 1'b1;
      s_r.wr <= 1'b1;
      s_r.arr <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign S_AXI_AWREADY = s_r.awr;
  assign S_AXI_WREADY = s_r.wr;
  assign S_AXI_BVALID = s_r.bv;
  assign S_AXI_BRESP = s_r.br;
  assign S_AXI_ARREADY = s_r.arr;
  assign S_AXI_RVALID = s_r.rv;
  assign S_AXI_RDATA = {24'h000000, s_r.rd};
  assign S_AXI_RRESP = s_r.rr;
  assign PINS = s_r.pins;
  assign IRQ = s_r.irq;
endmodule

/* pwr_bridge.sv */
// Power bridge model seen through the pin pull-down resistors.
`timescale 1ns/1ps
module pwr_bridge (
  input wire pwm_out_pkg::pins_s pins,
  output logic [5:0] gate
);
  // A released pin is pulled low, so its switch stays off.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      gate[i] = pins.oe[i] ? pins.out[i] : 1'b0;
    end
  end
endmodule
